// ==== common/tts_send_defs.vh ====
`ifndef TTS_SEND_DEFS_VH
`define TTS_SEND_DEFS_VH

// kind of frame handed to the send-frame state
`define KIND_DATA 2'h0
`define KIND_XFER_RDY 2'h1
`define KIND_RESPONSE 2'h2

// port-layer transmission status codes
`define CONF_FRAME_TX 3'h0
`define CONF_ACK 3'h1
`define CONF_NAK 3'h2
`define CONF_TIMEOUT 3'h3
`define CONF_CONN_LOST 3'h4
`define CONF_CANCEL_ACK 3'h5
`define CONF_NEXUS_LOSS 3'h6

// transmission complete message codes
`define DONE_XFER_DELIVERED 4'h0
`define DONE_RESP_DELIVERED 4'h1
`define DONE_DATA_DELIVERED 4'h2
`define DONE_RESP_FAILED 4'h3
`define DONE_XFER_FAIL_NAK 4'h4
`define DONE_XFER_FAIL_CONN 4'h5
`define DONE_DATA_FAIL_NAK 4'h6
`define DONE_DATA_FAIL_CONN 4'h7
`define DONE_TERMINATED 4'h8
`define DONE_NEXUS_LOSS 4'h9

// state codes shown on the state output
`define STATE_START 3'h0
`define STATE_SEND 3'h1
`define STATE_PREPARE 3'h2
`define STATE_WRITE_RX 3'h3
`define STATE_CANCEL 3'h4

// reset values
`define OFFSET_RESET 0
`define DEFAULT_RETRY_LIMIT 3

`endif

// ==== hdl/event_counter.v ====
`timescale 1ns/1ps
`default_nettype none

// up/down counter used for outstanding requests and for retries since the last ack;
// clear wins over inc/dec so a reset of the count is never half applied
module event_counter #(
  parameter W = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire clear,
  input wire inc,
  input wire dec,
  // count
  output reg [W-1:0] count
);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {W{1'b0}};
    end else if (clear) begin
      count <= {W{1'b0}};
    end else if (inc && !dec) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end else if (dec && !inc && (count != {W{1'b0}})) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ==== hdl/tts_send_frame.v ====
// Function
// R1: ACK on XFER_RDY reports xfer-ready delivered with transfer tag.
// R2: ACK on RESPONSE reports response delivered.
// R3: data ACK reports data-in delivered only when offsets all match.
// R4: failed RESPONSE with retry limit reached reports response failed.
// R5: failed XFER_RDY without retries left reports NAK or connection variant.
// R6: failed DATA frame without retries left reports NAK or connection variant.
// R7: cancel with nothing outstanding reports data transfer terminated.
// R8: cancel with requests outstanding issues port cancel with address and tag.
// R9: cancel acknowledged by port reports data transfer terminated.
// R10: every completion carries destination address and tag.
// R11: any completion except xfer-ready delivered returns to start.
// R12: data frame transmitted below requested count goes to data-in prepare.
// R13: retryable data failure goes to data-in prepare with retry flag.
// R14: after xfer-ready delivered go to write-data receive.
// R15: each data ACK adds its frame bytes to the balance offset.
// R16: per-frame retry counter compared with configurable limit; here it carries over frames until ack, loss or start.
`timescale 1ns/1ps
`default_nettype none
`include "tts_send_defs.vh"

module tts_send_frame #(
  parameter ADDR_W = 64,
  parameter TAG_W = 16,
  parameter OFF_W = 24,
  parameter RTY_W = 4,
  parameter OUT_W = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // frame hand-off from the prepare states
  input wire frame_start,
  input wire [1:0] frame_kind,
  input wire [OFF_W-1:0] frame_bytes,
  input wire [TAG_W-1:0] frame_ttag,
  // command arguments
  input wire [ADDR_W-1:0] dest_addr,
  input wire [TAG_W-1:0] cmd_tag,
  input wire [OFF_W-1:0] req_bytes,
  // cancel from the transfer manager
  input wire cancel,
  // retry configuration
  input wire retry_enable,
  input wire [RTY_W-1:0] retry_limit,
  // port-layer confirmations
  input wire conf_valid,
  input wire [2:0] conf_code,
  input wire [OFF_W-1:0] conf_bytes,
  // completion messages to the transfer manager
  output reg done_valid,
  output reg [3:0] done_code,
  output reg [ADDR_W-1:0] done_addr,
  output reg [TAG_W-1:0] done_tag,
  output reg [TAG_W-1:0] done_ttag,
  // requests to the port layer
  output reg cancel_req,
  output reg [ADDR_W-1:0] cancel_addr,
  output reg [TAG_W-1:0] cancel_tag,
  output reg resend_req,
  // state and offsets
  output reg [2:0] state,
  output reg retry_flag,
  output reg [OFF_W-1:0] read_offset,
  output reg [OFF_W-1:0] balance_offset
);

  localparam [2:0] S_START = `STATE_START;
  localparam [2:0] S_SEND = `STATE_SEND;
  localparam [2:0] S_PREPARE = `STATE_PREPARE;
  localparam [2:0] S_WRITE_RX = `STATE_WRITE_RX;
  localparam [2:0] S_CANCEL = `STATE_CANCEL;
  localparam [OFF_W-1:0] OFF_ZERO = `OFFSET_RESET;

  function [OFF_W-1:0] add_off;
    input [OFF_W-1:0] a;
    input [OFF_W-1:0] b;
    begin
      add_off = a + b;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // latched frame and command context

  reg [1:0] kind;
  reg [OFF_W-1:0] cur_bytes;
  reg [TAG_W-1:0] ttag;
  reg [ADDR_W-1:0] addr;
  reg [TAG_W-1:0] tag;
  reg [OFF_W-1:0] req;

  wire [OUT_W-1:0] outstanding;
  wire [RTY_W-1:0] retries;

  wire take_frame = frame_start && (state != S_CANCEL);
  wire is_ack = conf_valid && (conf_code == `CONF_ACK);
  wire is_tx = conf_valid && (conf_code == `CONF_FRAME_TX);
  wire is_nak = conf_valid && (conf_code == `CONF_NAK);
  wire is_fail = conf_valid && ((conf_code == `CONF_NAK) ||
                 (conf_code == `CONF_TIMEOUT) ||
                 (conf_code == `CONF_CONN_LOST));
  wire is_cack = conf_valid && (conf_code == `CONF_CANCEL_ACK);
  wire is_loss = conf_valid && (conf_code == `CONF_NEXUS_LOSS);
  // retries disabled counts as limit reached
  wire retry_ok = retry_enable && (retries < retry_limit); // R16
  wire [OFF_W-1:0] read_sum = add_off(read_offset, cur_bytes);
  wire [OFF_W-1:0] bal_sum = add_off(balance_offset, conf_bytes);
  wire in_flight = (state == S_SEND) || (state == S_PREPARE);
  wire do_resend = in_flight && is_fail && retry_ok &&
                   (kind != `KIND_DATA);
  wire do_retry = in_flight && is_fail && retry_ok &&
                  (kind == `KIND_DATA);
  wire to_start = (state == S_START);

  //////////////////////////////////////////////////////////////////////////
  // counters

  // a frame taken in the start state must count, or a later cancel
  // would believe nothing is outstanding
  event_counter #(.W(OUT_W)) u_outstanding (
    .clk(clk),
    .rst_b(rst_b),
    .clear(is_cack || is_loss || (to_start && !take_frame)),
    .inc(take_frame || do_resend),
    .dec(is_ack || is_fail),
    .count(outstanding)
  );

  // one count across frames: cleared only on an acknowledge, a nexus loss or in the start state, not when a new frame is taken
  event_counter #(.W(RTY_W)) u_retries (
    .clk(clk),
    .rst_b(rst_b),
    .clear(is_ack || is_loss || to_start),
    .inc(do_resend || do_retry),
    .dec(1'b0),
    .count(retries)
  ); // R16

  //////////////////////////////////////////////////////////////////////////
  // send-frame state machine

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_START;
      kind <= `KIND_DATA;
      cur_bytes <= OFF_ZERO;
      ttag <= {TAG_W{1'b0}};
      addr <= {ADDR_W{1'b0}};
      tag <= {TAG_W{1'b0}};
      req <= OFF_ZERO;
      read_offset <= OFF_ZERO;
      balance_offset <= OFF_ZERO;
      done_valid <= 1'b0;
      done_code <= `DONE_TERMINATED;
      done_addr <= {ADDR_W{1'b0}};
      done_tag <= {TAG_W{1'b0}};
      done_ttag <= {TAG_W{1'b0}};
      cancel_req <= 1'b0;
      cancel_addr <= {ADDR_W{1'b0}};
      cancel_tag <= {TAG_W{1'b0}};
      resend_req <= 1'b0;
      retry_flag <= 1'b0;
    end else begin
      done_valid <= 1'b0;
      cancel_req <= 1'b0;
      resend_req <= 1'b0;
      done_addr <= addr; // R10
      done_tag <= tag; // R10
      done_ttag <= ttag;
      if (state == S_START) begin
        read_offset <= OFF_ZERO;
        balance_offset <= OFF_ZERO;
      end else if (is_ack && (kind == `KIND_DATA)) begin
        balance_offset <= bal_sum; // R15
      end
      if (take_frame) begin
        state <= S_SEND;
        kind <= frame_kind;
        cur_bytes <= frame_bytes;
        ttag <= frame_ttag;
        addr <= dest_addr;
        tag <= cmd_tag;
        req <= req_bytes;
        retry_flag <= 1'b0;
      end else begin
        case (state)
          S_SEND, S_PREPARE: begin
            if (cancel) begin
              if (outstanding == {OUT_W{1'b0}}) begin
                done_valid <= 1'b1; // R7
                done_code <= `DONE_TERMINATED;
                state <= S_START; // R11
              end else begin
                cancel_req <= 1'b1; // R8
                cancel_addr <= addr;
                cancel_tag <= tag;
                state <= S_CANCEL;
              end
            end else if (is_loss) begin
              done_valid <= 1'b1;
              done_code <= `DONE_NEXUS_LOSS;
              state <= S_START;
            end else if (is_tx && (kind == `KIND_DATA)) begin
              read_offset <= read_sum;
              if (read_sum < req) begin
                state <= S_PREPARE; // R12
              end
            end else if (is_ack) begin
              if (kind == `KIND_XFER_RDY) begin
                done_valid <= 1'b1; // R1
                done_code <= `DONE_XFER_DELIVERED;
                state <= S_WRITE_RX; // R14
              end else if (kind == `KIND_RESPONSE) begin
                done_valid <= 1'b1; // R2
                done_code <= `DONE_RESP_DELIVERED;
                state <= S_START; // R11
              end else if ((read_offset == req) &&
                           (read_offset == bal_sum)) begin
                done_valid <= 1'b1; // R3
                done_code <= `DONE_DATA_DELIVERED;
                state <= S_START; // R11
              end
            end else if (do_resend) begin
              resend_req <= 1'b1;
            end else if (do_retry) begin
              state <= S_PREPARE; // R13
              retry_flag <= 1'b1;
            end else if (is_fail) begin
              done_valid <= 1'b1;
              state <= S_START; // R11
              if (kind == `KIND_RESPONSE) begin
                done_code <= `DONE_RESP_FAILED; // R4
              end else if (kind == `KIND_XFER_RDY) begin
                done_code <= is_nak ? `DONE_XFER_FAIL_NAK :
                             `DONE_XFER_FAIL_CONN; // R5
              end else begin
                done_code <= is_nak ? `DONE_DATA_FAIL_NAK :
                             `DONE_DATA_FAIL_CONN; // R6
              end
            end
          end
          S_CANCEL: begin
            if (is_cack || is_loss) begin
              done_valid <= 1'b1; // R9
              done_code <= is_cack ? `DONE_TERMINATED : `DONE_NEXUS_LOSS;
              state <= S_START; // R11
            end
          end
          S_WRITE_RX: begin
            // write data is handled elsewhere; a cancel ends the command
            if (cancel) begin
              done_valid <= 1'b1;
              done_code <= `DONE_TERMINATED;
              state <= S_START;
            end
          end
          default: begin
            state <= S_START;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/tts_send_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tts_send_defs.vh"
module tts_send_chk #(
  parameter ADDR_W = 64,
  parameter TAG_W = 16,
  parameter OFF_W = 24
) (
  // requests
  input wire logic clk, rst_b, frame_start, cancel, retry_enable,
  input wire logic [1:0] frame_kind,
  input wire logic [ADDR_W-1:0] dest_addr,
  input wire logic [TAG_W-1:0] cmd_tag, frame_ttag,
  input wire logic [OFF_W-1:0] req_bytes, conf_bytes,
  input wire logic conf_valid,
  input wire logic [2:0] conf_code,
  // answers
  input wire logic done_valid, cancel_req,
  input wire logic [3:0] done_code,
  input wire logic [2:0] state,
  input wire logic [ADDR_W-1:0] cancel_addr,
  input wire logic [TAG_W-1:0] done_ttag, cancel_tag,
  input wire logic [OFF_W-1:0] read_offset, balance_offset
);
  logic [1:0] k;
  logic [ADDR_W-1:0] d;
  logic [TAG_W-1:0] t, tt;
  logic [OFF_W-1:0] rq;
  // a confirmation only counts when no frame or cancel outranks it
  wire tk = conf_valid && !frame_start && !cancel && state == `STATE_SEND;
  wire ack = tk && conf_code == `CONF_ACK;
  wire fl = tk && conf_code inside {`CONF_NAK, `CONF_TIMEOUT, `CONF_CONN_LOST};
  wire kd = k == `KIND_DATA;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) begin
      {k, d, t, tt, rq} <= '0;
    end else if (frame_start) begin
      {k, d, t, tt, rq} <= {frame_kind, dest_addr, cmd_tag, frame_ttag, req_bytes};
    end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_xfer_ack: assert property (ack && k == `KIND_XFER_RDY |=> done_valid
    && done_code == `DONE_XFER_DELIVERED && done_ttag == tt && state == `STATE_WRITE_RX)
    else $error("bad xfer ack");
  a_resp_ack: assert property (ack && k == `KIND_RESPONSE |=> done_valid
    && done_code == `DONE_RESP_DELIVERED && state == `STATE_START) else $error("bad resp ack");
  a_resp_fail: assert property (fl && k == `KIND_RESPONSE && !retry_enable
    |=> done_valid && done_code == `DONE_RESP_FAILED) else $error("bad resp fail");
  a_xfer_nak: assert property (fl && k == `KIND_XFER_RDY && !retry_enable
    && conf_code == `CONF_NAK |=> done_code == `DONE_XFER_FAIL_NAK) else $error("bad xfer nak");
  a_data_done: assert property (ack && kd |=> (done_valid && done_code ==
    `DONE_DATA_DELIVERED) == ($past(balance_offset) + $past(conf_bytes) == rq
    && $past(read_offset) == rq)) else $error("bad data done");
  a_balance_ack: assert property (ack && kd |=> balance_offset ==
    $past(balance_offset) + $past(conf_bytes)) else $error("bad balance");
  a_data_sent: assert property (tk && kd && conf_code == `CONF_FRAME_TX |=>
    (state == `STATE_PREPARE) == (read_offset < rq)) else $error("bad data tx");
  a_cancel_args: assert property (cancel_req |-> cancel_addr == d && cancel_tag == t)
    else $error("bad cancel args");
  a_cancel_ack: assert property (state == `STATE_CANCEL && conf_valid && !cancel
    && !frame_start && conf_code == `CONF_CANCEL_ACK |=> done_valid
    && done_code == `DONE_TERMINATED ##0 state == `STATE_START) else $error("bad cancel ack");
  c_xfer: cover property (ack && k == `KIND_XFER_RDY);
  c_cancel: cover property (cancel_req);
  c_data: cover property (ack && kd);
endmodule
bind tts_send_frame tts_send_chk #(.ADDR_W(ADDR_W), .TAG_W(TAG_W), .OFF_W(OFF_W))
  i_chk (.*);
`default_nettype wire

// ==== test/port_layer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// answers each request lat+1 cycles after it is taken; outside the answer the lines churn
// so a design reading them at the wrong time sees garbage, not stale data
module port_layer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request from the bench
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic [11:0] bytes,
  input wire logic [1:0] lat,
  // confirmation to the block
  output logic conf_valid,
  output logic [2:0] conf_code,
  output logic [11:0] conf_bytes
);
  logic busy;
  logic [1:0] n;
  logic [2:0] c;
  logic [11:0] b;
  wire fire = busy && n == 2'h0;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) begin
      {busy, n, c, b, conf_valid, conf_code, conf_bytes} <= '0;
    end else begin
      conf_valid <= fire;
      conf_code <= fire ? c : ~conf_code;
      conf_bytes <= fire ? b : ~conf_bytes;
      if (go) begin
        {busy, n, c, b} <= {1'b1, lat, code, bytes};
      end else if (busy) begin
        busy <= !fire;
        n <= n - 2'h1;
      end
    end
endmodule
`default_nettype wire

// ==== test/tts_send_frame_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tts_send_defs.vh"
module tts_send_frame_tb;
  logic clk = 0, rst_b = 0, fs = 0, cn = 0, re = 0, go = 0;
  logic [1:0] kd = 0, lt = 0;
  logic [11:0] fb = 0, rq = 0, gb = 0;
  logic [2:0] gc = 0;
  logic [3:0] lim = 4'h1;
  logic [15:0] dad = 16'ha5c3;
  logic [7:0] ttg = 8'h3c, ctg = 8'h5e;
  wire cv, dv, crq, rf, rs;
  wire [2:0] cc, st;
  wire [11:0] cb, ro, bo;
  wire [3:0] dc;
  wire [15:0] da, ca;
  wire [7:0] dt, dtt, ct;
  int num_errors = 0, n_checks = 0;
  tts_send_frame #(.ADDR_W(16), .TAG_W(8), .OFF_W(12)) i_dut (
    .clk(clk), .rst_b(rst_b), .frame_start(fs), .frame_kind(kd),
    .frame_bytes(fb), .frame_ttag(ttg), .dest_addr(dad),
    .cmd_tag(ctg), .req_bytes(rq), .cancel(cn), .retry_enable(re),
    .retry_limit(lim), .conf_valid(cv), .conf_code(cc), .conf_bytes(cb),
    .done_valid(dv), .done_code(dc), .done_addr(da), .done_tag(dt),
    .done_ttag(dtt), .cancel_req(crq), .cancel_addr(ca), .cancel_tag(ct),
    .resend_req(rs), .state(st), .retry_flag(rf), .read_offset(ro),
    .balance_offset(bo));
  port_layer_model i_port (.clk(clk), .rst_b(rst_b), .go(go), .code(gc),
    .bytes(gb), .lat(lt), .conf_valid(cv), .conf_code(cc), .conf_bytes(cb));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic frm(logic [1:0] k, logic [11:0] b);
    @(posedge clk);
    {fs, kd, fb} <= {1'b1, k, b};
    @(posedge clk);
    fs <= 1'b0;
  endtask
  // returns once the answer shows; the block takes it at the next edge
  task automatic conf(logic [2:0] c, logic [11:0] b);
    @(posedge clk);
    {go, gc, gb} <= {1'b1, c, b};
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 9 && cv !== 1'b1; i++) tick();
  endtask
  task automatic stop_it;
    @(posedge clk);
    cn <= 1'b1;
    @(posedge clk);
    cn <= 1'b0;
    #1;
  endtask
  task automatic wdone(logic [3:0] code, logic [2:0] s);
    for (int i = 0; i < 9 && dv !== 1'b1; i++) tick();
    chk("done_valid", 1'b1, dv);
    chk("done_code", code, dc);
    chk("done_addr", 16'ha5c3, da);
    chk("done_tag", 8'h5e, dt);
    chk("state", s, st);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_xfer;
    frm(`KIND_XFER_RDY, 12'h000);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_ACK, 12'h000);
    wdone(`DONE_XFER_DELIVERED, `STATE_WRITE_RX);
    chk("done_ttag", 8'h3c, dtt);
    stop_it();
    wdone(`DONE_TERMINATED, `STATE_START);
    $display("xfer test over");
  endtask
  // two frames, acks arrive slowly; first ack must not complete
  task automatic t_data;
    rq <= 12'h040;
    lt <= 2'h2;
    frm(`KIND_DATA, 12'h020);
    conf(`CONF_FRAME_TX, 12'h000);
    tick();
    chk("state", `STATE_PREPARE, st);
    chk("read_offset", 12'h020, ro);
    frm(`KIND_DATA, 12'h020);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_ACK, 12'h020);
    tick();
    chk("done_valid", 1'b0, dv);
    chk("balance", 12'h020, bo);
    conf(`CONF_ACK, 12'h020);
    wdone(`DONE_DATA_DELIVERED, `STATE_START);
    chk("balance", 12'h040, bo);
    lt <= 2'h0;
    $display("data test over");
  endtask
  task automatic t_fail;
    logic [1:0] k [9] = '{2, 2, 1, 1, 1, 0, 0, 0, 2};
    logic [2:0] c [9] = '{`CONF_NAK, `CONF_CONN_LOST, `CONF_NAK,
      `CONF_TIMEOUT, `CONF_CONN_LOST, `CONF_NAK, `CONF_TIMEOUT,
      `CONF_CONN_LOST, `CONF_ACK};
    logic [3:0] e [9] = '{`DONE_RESP_FAILED, `DONE_RESP_FAILED,
      `DONE_XFER_FAIL_NAK, `DONE_XFER_FAIL_CONN, `DONE_XFER_FAIL_CONN,
      `DONE_DATA_FAIL_NAK, `DONE_DATA_FAIL_CONN, `DONE_DATA_FAIL_CONN,
      `DONE_RESP_DELIVERED};
    for (int i = 0; i < 9; i++) begin
      frm(k[i], rq);
      conf(`CONF_FRAME_TX, 12'h000);
      conf(c[i], rq);
      wdone(e[i], `STATE_START);
    end
    $display("failure test over");
  endtask
  task automatic t_retry;
    re <= 1'b1;
    frm(`KIND_DATA, rq);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_TIMEOUT, 12'h000);
    tick();
    chk("state", `STATE_PREPARE, st);
    chk("retry_flag", 1'b1, rf);
    frm(`KIND_DATA, rq);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_NAK, 12'h000);
    wdone(`DONE_DATA_FAIL_NAK, `STATE_START);
    // a failed response with retries left is resent, then gives up
    frm(`KIND_RESPONSE, 12'h000);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_NAK, 12'h000);
    tick();
    chk("resend_req", 1'b1, rs);
    chk("state", `STATE_SEND, st);
    conf(`CONF_NAK, 12'h000);
    wdone(`DONE_RESP_FAILED, `STATE_START);
    re <= 1'b0;
    $display("retry test over");
  endtask
  task automatic t_cancel;
    // every frame acked but the data is short: cancel ends at once
    frm(`KIND_DATA, 12'h020);
    conf(`CONF_FRAME_TX, 12'h000);
    conf(`CONF_ACK, 12'h020);
    stop_it();
    wdone(`DONE_TERMINATED, `STATE_START);
    frm(`KIND_RESPONSE, 12'h000);
    stop_it();
    chk("cancel_req", 1'b1, crq);
    chk("cancel_addr", 16'ha5c3, ca);
    chk("cancel_tag", 8'h5e, ct);
    chk("state", `STATE_CANCEL, st);
    conf(`CONF_CANCEL_ACK, 12'h000);
    wdone(`DONE_TERMINATED, `STATE_START);
    $display("cancel test over");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_xfer();
    t_data();
    t_fail();
    t_retry();
    t_cancel();
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
